// *** verilog/xim_pkg.sv ***
package xim_pkg;

  // ==========================================================
  // SFR map
  localparam logic [7:0] XIM_ADDR_ENABLE_ONE   = 8'hE6;
  localparam logic [7:0] XIM_ADDR_ENABLE_TWO   = 8'hE7;
  localparam logic [7:0] XIM_ADDR_PRIORITY_ONE = 8'hF6;

  // ==========================================================
  // Reset values and implemented-bit masks
  localparam logic [7:0] XIM_RST_ENABLE_ONE   = 8'h00;
  localparam logic [7:0] XIM_RST_ENABLE_TWO   = 8'h00;
  localparam logic [7:0] XIM_RST_PRIORITY_ONE = 8'h00;
  localparam logic [7:0] XIM_MASK_ENABLE_TWO  = 8'h5F;

  // ==========================================================
  // Source numbering: 0..7 first enable register, 8..15 second
  localparam int XIM_NUM_SRC = 16;
  localparam int XIM_SRC_ID_W = 4;

  // First enable register bit positions
  localparam int XIM_BIT_SPI          = 0;
  localparam int XIM_BIT_SMBUS        = 1;
  localparam int XIM_BIT_CONV_A_WIN   = 2;
  localparam int XIM_BIT_COUNTER_ARR  = 3;
  localparam int XIM_BIT_CMP_A_FALL   = 4;
  localparam int XIM_BIT_CMP_A_RISE   = 5;
  localparam int XIM_BIT_CMP_B_FALL   = 6;
  localparam int XIM_BIT_CMP_B_RISE   = 7;
  // Second enable register bit positions
  localparam int XIM_BIT_TIMER_THREE  = 0;
  localparam int XIM_BIT_CONV_A_DONE  = 1;
  localparam int XIM_BIT_TIMER_FOUR   = 2;
  localparam int XIM_BIT_CONV_B_WIN   = 3;
  localparam int XIM_BIT_CONV_B_DONE  = 4;
  localparam int XIM_BIT_UART_B       = 6;

  // ==========================================================
  // Special-function-register bus beat
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xim_sfr_req_type;

  // Winner of arbitration
  typedef struct packed {
    logic                    valid;
    logic                    high;
    logic [XIM_SRC_ID_W-1:0] id;
  } xim_grant_type;

endpackage : xim_pkg

// *** verilog/xim_level_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Fixed-order pick: lowest index wins
module xim_level_pick (
  input  wire logic [xim_pkg::XIM_NUM_SRC-1:0]  req,
  output logic                                  any,
  output logic [xim_pkg::XIM_SRC_ID_W-1:0]      id
);

  logic [xim_pkg::XIM_NUM_SRC-1:0] lower_any;

  assign lower_any[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 1; gi < xim_pkg::XIM_NUM_SRC; gi++) begin : g_chain
      assign lower_any[gi] = lower_any[gi-1] | req[gi-1];
    end
  endgenerate

  always_comb begin
    id = '0;
    for (int k = xim_pkg::XIM_NUM_SRC - 1; k >= 0; k--) begin
      if (req[k] && !lower_any[k]) begin
        id = k[xim_pkg::XIM_SRC_ID_W-1:0];
      end
    end
  end

  assign any = |req;

endmodule : xim_level_pick

`default_nettype wire

// *** verilog/xim_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module xim_ctrl (
  input  wire logic                                 clk_sys,
  input  wire logic                                 srst,
  input  wire xim_pkg::xim_sfr_req_type             sfr_req,
  input  wire logic                                 sfr_rd_en,
  output logic [7:0]                                sfr_rdata,
  output logic                                      sfr_hit,
  input  wire logic                                 global_irq_enable,
  input  wire logic [xim_pkg::XIM_NUM_SRC-1:0]      src_req,
  input  wire logic                                 svc_low_active,
  input  wire logic                                 svc_high_active,
  output logic                                      irq_valid,
  output logic                                      irq_high,
  output logic [xim_pkg::XIM_SRC_ID_W-1:0]          irq_id,
  output logic [xim_pkg::XIM_NUM_SRC-1:0]           src_gated
);

  // ==========================================================
  // Registers
  logic [7:0] enable_one_r;
  logic [7:0] enable_one_nxt;
  logic [7:0] enable_two_r;
  logic [7:0] enable_two_nxt;
  logic [7:0] priority_one_r;
  logic [7:0] priority_one_nxt;
  xim_pkg::xim_grant_type grant_r;
  xim_pkg::xim_grant_type grant_nxt;

  // ==========================================================
  // Address decode, page-independent
  wire hit_en1 = (sfr_req.addr == xim_pkg::XIM_ADDR_ENABLE_ONE);
  wire hit_en2 = (sfr_req.addr == xim_pkg::XIM_ADDR_ENABLE_TWO);
  wire hit_pr1 = (sfr_req.addr == xim_pkg::XIM_ADDR_PRIORITY_ONE);
  wire any_hit = hit_en1 | hit_en2 | hit_pr1;

  assign enable_one_nxt   = (sfr_req.wr_en && hit_en1) ? sfr_req.wdata : enable_one_r;
  // Unused positions forced to zero on store
  assign enable_two_nxt   = (sfr_req.wr_en && hit_en2)
                          ? (sfr_req.wdata & xim_pkg::XIM_MASK_ENABLE_TWO)
                          : enable_two_r;
  assign priority_one_nxt = (sfr_req.wr_en && hit_pr1) ? sfr_req.wdata : priority_one_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_one_r   <= xim_pkg::XIM_RST_ENABLE_ONE;
      enable_two_r   <= xim_pkg::XIM_RST_ENABLE_TWO;
      priority_one_r <= xim_pkg::XIM_RST_PRIORITY_ONE;
    end else begin
      enable_one_r   <= enable_one_nxt;
      enable_two_r   <= enable_two_nxt;
      priority_one_r <= priority_one_nxt;
    end
  end

  // ==========================================================
  // Read path, combinational
  wire [7:0] rd_sel = hit_en1 ? enable_one_r
                    : hit_en2 ? (enable_two_r & xim_pkg::XIM_MASK_ENABLE_TWO)
                    : hit_pr1 ? priority_one_r
                    : 8'h00;
  assign sfr_rdata = sfr_rd_en ? rd_sel : 8'h00;
  assign sfr_hit   = any_hit & (sfr_rd_en | sfr_req.wr_en);

  // ==========================================================
  // Masking: sources 0..7 first register, 8..15 second
  wire [15:0] enable_all = {enable_two_r, enable_one_r};
  // Sources without priority bit here sit at low level
  wire [15:0] prio_all   = {8'h00, priority_one_r};

  // Each source gated by its own bit and the global enable
  assign src_gated = global_irq_enable ? (src_req & enable_all) : '0;

  wire [15:0] req_high = src_gated & prio_all;
  wire [15:0] req_low  = src_gated & ~prio_all;

  logic                               high_any;
  logic [xim_pkg::XIM_SRC_ID_W-1:0]   high_id;
  logic                               low_any;
  logic [xim_pkg::XIM_SRC_ID_W-1:0]   low_id;

  xim_level_pick u_pick_high (
    .req (req_high),
    .any (high_any),
    .id  (high_id)
  );

  xim_level_pick u_pick_low (
    .req (req_low),
    .any (low_any),
    .id  (low_id)
  );

  // ==========================================================
  // Preemption: high may break low service; nothing breaks high
  wire high_ok = high_any && !svc_high_active;
  wire low_ok  = low_any && !svc_high_active && !svc_low_active;

  always_comb begin
    grant_nxt = '0;
    if (high_ok) begin
      grant_nxt.valid = 1'b1;
      grant_nxt.high  = 1'b1;
      grant_nxt.id    = high_id;
    end else if (low_ok) begin
      grant_nxt.valid = 1'b1;
      grant_nxt.id    = low_id;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      grant_r <= '0;
    end else begin
      grant_r <= grant_nxt;
    end
  end

  assign irq_valid = grant_r.valid;
  assign irq_high  = grant_r.high;
  assign irq_id    = grant_r.id;

  // ==========================================================
  // Checks
  logic past_valid_r;
  // Set at the first edge, kept through reset so the reset check can see it
  always_ff @(posedge clk_sys) begin
    past_valid_r <= 1'b1;
  end

  unused_bits_a: assert property (@(posedge clk_sys) disable iff (srst)
    (enable_two_r[7] == 1'b0) && (enable_two_r[5] == 1'b0))
    else $error("unused enable bits set");

  en2_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_req.wr_en && sfr_req.addr == 8'hE7) |=> (enable_two_r == ($past(sfr_req.wdata) & 8'h5F)))
    else $error("second enable write lost");

  global_block_a: assert property (@(posedge clk_sys) disable iff (srst)
    !global_irq_enable |-> (src_gated == 16'h0000))
    else $error("source passed with global enable off");

  uart_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    (global_irq_enable && src_req[14]) |-> (src_gated[14] == enable_two_r[6]))
    else $error("uart mask wrong");

  spi_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    (global_irq_enable && src_req[0]) |-> (src_gated[0] == enable_one_r[0]))
    else $error("spi mask wrong");

  no_low_preempt_a: assert property (@(posedge clk_sys) disable iff (srst)
    svc_low_active |=> !(irq_valid && !irq_high))
    else $error("low preempted low");

  high_blocks_a: assert property (@(posedge clk_sys) disable iff (srst)
    svc_high_active |=> !irq_valid)
    else $error("grant during high service");

  high_wins_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[5] && priority_one_r[5] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("high request not granted high");

  reset_clear_a: assert property (@(posedge clk_sys)
    (past_valid_r && $past(srst)) |-> (enable_one_r == 8'h00 && priority_one_r == 8'h00
                                       && enable_two_r == 8'h00 && !irq_valid))
    else $error("registers not cleared by reset");

  // ==========================================================
  // Per-source masks, levels, arbitration and register access
  conv_b_done_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[12] == (src_req[12] & enable_two_r[4])))
    else $error("secondary conversion mask wrong");

  conv_b_win_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[11] == (src_req[11] & enable_two_r[3])))
    else $error("secondary window mask wrong");

  timer4_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[10] == (src_req[10] & enable_two_r[2])))
    else $error("timer four mask wrong");

  conv_a_done_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[9] == (src_req[9] & enable_two_r[1])))
    else $error("primary conversion mask wrong");

  timer3_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[8] == (src_req[8] & enable_two_r[0])))
    else $error("timer three mask wrong");

  cmp_a_rise_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[5] == (src_req[5] & enable_one_r[5])))
    else $error("comparator rise mask wrong");

  conv_a_win_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated[2] == (src_req[2] & enable_one_r[2])))
    else $error("primary window mask wrong");

  global_pass_a: assert property (@(posedge clk_sys) disable iff (srst)
    global_irq_enable |-> (src_gated == (src_req & {enable_two_r, enable_one_r})))
    else $error("source blocked with global enable on");

  cmp_b_fall_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[6] && priority_one_r[6] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("comparator b fall not high");

  cmp_a_fall_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[4] && priority_one_r[4] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("comparator a fall not high");

  counter_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[3] && priority_one_r[3] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("counter array not high");

  conv_win_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[2] && priority_one_r[2] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("window compare not high");

  smbus_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[1] && priority_one_r[1] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("smbus not high");

  spi_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[0] && priority_one_r[0] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("spi not high");

  cmp_b_rise_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[7] && priority_one_r[7] && !svc_high_active) |=> (irq_valid && irq_high))
    else $error("comparator b rise not high");

  cmp_a_rise_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[5] && !priority_one_r[5]) |=> !(irq_valid && irq_high && irq_id == 4'h5))
    else $error("comparator a rise granted high");

  smbus_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[1] && !priority_one_r[1]) |=> !(irq_valid && irq_high && irq_id == 4'h1))
    else $error("smbus granted high");

  spi_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[0] && !priority_one_r[0]) |=> !(irq_valid && irq_high && irq_id == 4'h0))
    else $error("spi granted high");

  cmp_b_rise_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[7] && !priority_one_r[7]) |=> !(irq_valid && irq_high && irq_id == 4'h7))
    else $error("comparator b rise granted high");

  upper_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated[7:0] == 8'h00) |=> !irq_high)
    else $error("second register source granted high");

  idle_no_grant_a: assert property (@(posedge clk_sys) disable iff (srst)
    (src_gated == 16'h0000) |=> !irq_valid)
    else $error("grant without request");

  high_order_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_high[0] && !svc_high_active) |=> (irq_valid && irq_high && irq_id == 4'h0))
    else $error("fixed order broken at high level");

  low_order_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_high == 16'h0000 && req_low[0] && !svc_high_active && !svc_low_active)
    |=> (irq_valid && !irq_high && irq_id == 4'h0))
    else $error("fixed order broken at low level");

  en2_read_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_rd_en && hit_en2) |-> (sfr_rdata[7] == 1'b0 && sfr_rdata[5] == 1'b0))
    else $error("unused bits read nonzero");

  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_rd_en && !any_hit) |-> (sfr_rdata == 8'h00 && !sfr_hit))
    else $error("unmapped address answered");

  hit_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_req.wr_en && hit_en2) |-> sfr_hit)
    else $error("mapped write not flagged");

  en1_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_req.wr_en && hit_en1) |=> (enable_one_r == $past(sfr_req.wdata)))
    else $error("first enable write lost");

  pr1_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_req.wr_en && hit_pr1) |=> (priority_one_r == $past(sfr_req.wdata)))
    else $error("priority write lost");

  cv_high_grant: cover property (@(posedge clk_sys) disable iff (srst) irq_valid && irq_high);
  cv_low_grant: cover property (@(posedge clk_sys) disable iff (srst) irq_valid && !irq_high);
  cv_preempt: cover property (@(posedge clk_sys) disable iff (srst)
    svc_low_active ##1 (irq_valid && irq_high));
  cv_en2_write: cover property (@(posedge clk_sys) disable iff (srst) sfr_req.wr_en && hit_en2);

endmodule : xim_ctrl

`default_nettype wire

// *** verification/xim_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Core sequencer: enters service on acknowledge, leaves on return
module xim_core_model (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic irq_valid,
  input  wire logic irq_high,
  input  wire logic ack,
  input  wire logic reti,
  output logic      svc_low_active,
  output logic      svc_high_active
);
  always_ff @(posedge clk_sys) begin
    if (srst || reti) begin
      svc_low_active  <= 1'b0;
      svc_high_active <= 1'b0;
    end else if (ack && irq_valid) begin
      svc_high_active <= svc_high_active | irq_high;
      svc_low_active  <= svc_low_active | ~irq_high;
    end
  end
endmodule : xim_core_model

`default_nettype wire

// *** verification/extended_interrupt_mask_priority_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module extended_interrupt_mask_priority_tb_top;
  logic                     clk_sys = 1'b0;
  logic                     srst = 1'b1;
  xim_pkg::xim_sfr_req_type sfr_req = '0;
  logic                     sfr_rd_en = 1'b0;
  logic                     global_irq_enable = 1'b0;
  logic [15:0]              src_req = 16'h0000;
  logic                     ack = 1'b0;
  logic                     reti = 1'b0;
  logic [7:0]               sfr_rdata;
  logic [15:0]              src_gated;
  logic [3:0]               irq_id;
  logic                     sfr_hit, svc_low_active, svc_high_active, irq_valid, irq_high;
  int                       fail_count = 0;
  int                       comparisons = 0;
  int                       cycles = 0;

  always #2 clk_sys = ~clk_sys;

  xim_ctrl dut (.clk_sys(clk_sys), .srst(srst), .sfr_req(sfr_req), .sfr_rd_en(sfr_rd_en),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .global_irq_enable(global_irq_enable),
    .src_req(src_req), .svc_low_active(svc_low_active), .svc_high_active(svc_high_active),
    .irq_valid(irq_valid), .irq_high(irq_high), .irq_id(irq_id), .src_gated(src_gated));

  xim_core_model partner (.clk_sys(clk_sys), .srst(srst), .irq_valid(irq_valid),
    .irq_high(irq_high), .ack(ack), .reti(reti), .svc_low_active(svc_low_active),
    .svc_high_active(svc_high_active));

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr_en: 1'b1, addr: a, wdata: d};
    step();
    sfr_req.wr_en = 1'b0;
    step();
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    sfr_req.addr = a;
    sfr_rd_en = 1'b1;
    #1;
    chk({7'h00, sfr_hit, sfr_rdata}, {7'h00, hit, exp});
    step();
    sfr_rd_en = 1'b0;
    step();
  endtask : rd_chk

  function automatic logic [15:0] grant(input logic v, input logic h, input logic [3:0] id);
    return {10'h000, v, h, id};
  endfunction : grant

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    wr(8'hE7, 8'hFF);
    rd_chk(8'hE7, 8'h5F, 1'b1);
    wr(8'hE6, 8'hFF);
    rd_chk(8'hE6, 8'hFF, 1'b1);
    wr(8'hF6, 8'hA5);
    rd_chk(8'hF6, 8'hA5, 1'b1);
  endtask : t_regs

  task automatic t_reset();
    srst = 1'b1;
    step();
    srst = 1'b0;
    wr(8'hE5, 8'hFF);
    rd_chk(8'hE6, 8'h00, 1'b1);
    rd_chk(8'hE7, 8'h00, 1'b1);
    rd_chk(8'hF6, 8'h00, 1'b1);
    rd_chk(8'hE5, 8'h00, 1'b0);
  endtask : t_reset

  task automatic t_mask();
    logic [7:0] m;
    global_irq_enable = 1'b1;
    src_req = 16'hFFFF;
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      wr(8'hE6, 8'h00);
      wr(8'hE7, m);
      chk(src_gated, {m & 8'h5F, 8'h00});
      wr(8'hE7, 8'h00);
      wr(8'hE6, m);
      chk(src_gated, {8'h00, m});
    end
    wr(8'hE7, 8'hFF);
    global_irq_enable = 1'b0;
    #1;
    chk(src_gated, 16'h0000);
  endtask : t_mask

  task automatic t_prio();
    global_irq_enable = 1'b1;
    src_req = 16'h00FF;
    wr(8'hE7, 8'h00);
    wr(8'hE6, 8'hFF);
    wr(8'hF6, 8'h00);
    step();
    chk(grant(1'b1, 1'b0, 4'h0), grant(irq_valid, irq_high, irq_id));
    for (int b = 0; b < 8; b++) begin
      wr(8'hF6, 8'h01 << b);
      step();
      chk(grant(irq_valid, irq_high, irq_id), grant(1'b1, 1'b1, b[3:0]));
    end
  endtask : t_prio

  task automatic t_preempt();
    wr(8'hF6, 8'h01);
    wr(8'hE6, 8'h03);
    src_req = 16'h0002;
    step();
    chk(grant(irq_valid, irq_high, irq_id), grant(1'b1, 1'b0, 4'h1));
    ack = 1'b1;
    step();
    ack = 1'b0;
    step();
    chk(grant(irq_valid, irq_high, irq_id), 16'h0000);
    src_req = 16'h0003;
    step();
    chk(grant(irq_valid, irq_high, irq_id), grant(1'b1, 1'b1, 4'h0));
    ack = 1'b1;
    step();
    ack = 1'b0;
    step();
    chk(grant(irq_valid, irq_high, irq_id), 16'h0000);
    reti = 1'b1;
    step();
    reti = 1'b0;
    step();
    chk(grant(irq_valid, irq_high, irq_id), grant(1'b1, 1'b1, 4'h0));
  endtask : t_preempt

  // ==========================================================
  // Main sequence and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_regs();
    t_reset();
    t_mask();
    t_prio();
    t_preempt();
    summarize();
  end
endmodule : extended_interrupt_mask_priority_tb_top

`default_nettype wire
